//--- rtl/level_regfile_pkg.sv
package level_regfile_pkg;

  localparam int WORD_W    = 16;
  localparam int BUS_W     = 32;
  localparam int BE_W      = 4;
  localparam int ADDR_W    = 6;
  localparam int LEVELS    = 4;
  localparam int GPRS      = 8;
  localparam int LVL_W     = 2;
  localparam int GPR_W     = 3;
  localparam int LSB_BYTES = 22;
  localparam int LSB_WORDS = LSB_BYTES / 2;
  localparam int SIGN_BIT  = WORD_W - 1;
  localparam int BYTE_W    = 8;

  localparam logic [WORD_W-1:0] WORD_ONES  = 16'hFFFF;
  localparam logic [WORD_W-1:0] WORD_ZERO  = 16'h0000;
  localparam logic [WORD_W-1:0] INSTR_STEP = 16'h0002;

  // Register byte offsets on the bus.
  localparam logic [ADDR_W-1:0] OFF_CMD     = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_OPERAND = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_RESULT  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_LSR     = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_MASK    = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_PSW     = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_SAR     = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_CONBUF  = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_CURRENT_INSTR_ADDR_REG    = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_IAR     = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_LSB_SEL = 6'h2C;
  localparam logic [ADDR_W-1:0] OFF_LSB_DAT = 6'h30;

  // Level status register fields, numbered with bit 15 as the leftmost bit.
  localparam int LSR_EVEN     = 15;
  localparam int LSR_CARRY    = 14;
  localparam int LSR_OVF      = 13;
  localparam int LSR_NEG      = 12;
  localparam int LSR_ZERO     = 11;
  localparam logic [WORD_W-1:0] LSR_USED_MASK = 16'hF8F0;

  localparam int PSW_SPEC_BIT = 15;
  localparam logic [WORD_W-1:0] PSW_ERR_MASK = 16'hFFF0;

  localparam int ST_STOPPED = 0;
  localparam int ST_CLASS   = 1;

  localparam logic [3:0] LSB_IDX_IAR  = 4'h0;
  localparam logic [3:0] LSB_IDX_LSR  = 4'h1;
  localparam logic [3:0] LSB_IDX_GPR0 = 4'h2;

  localparam logic [LEVELS-1:0] MASK_RESET = 4'h0;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR  = 3'h3,
    ALU_XOR = 3'h4
  } alu_op_e;

  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_ADD      = 4'h1,
    OP_SUB      = 4'h2,
    OP_AND      = 4'h3,
    OP_OR       = 4'h4,
    OP_XOR      = 4'h5,
    OP_NEG      = 4'h6,
    OP_LOAD     = 4'h7,
    OP_LOAD_S8  = 4'h8,
    OP_COPY_CON = 4'h9,
    OP_FETCH    = 4'hA,
    OP_BRANCH   = 4'hB,
    OP_WORD_EA  = 4'hC,
    OP_RUN      = 4'hD,
    OP_STOP     = 4'hE,
    OP_READ_GPR = 4'hF
  } cmd_op_e;

  typedef struct packed {
    logic [3:0]       pad;
    logic [GPR_W-1:0] r2;
    logic [GPR_W-1:0] r1;
    logic [LVL_W-1:0] level;
    cmd_op_e          op;
  } cmd_s;

  typedef struct packed {
    logic [WORD_W-LVL_W-5:0] pad;
    logic [LVL_W-1:0]        level;
    logic [3:0]              word;
  } lsb_sel_s;

  typedef struct packed {
    logic [WORD_W-1:0] result;
    logic              carry;
    logic              overflow;
  } alu_out_s;

endpackage : level_regfile_pkg

//--- rtl/alu16.sv
`timescale 1ns/1ns
module alu16 (
  input  wire logic [level_regfile_pkg::WORD_W-1:0] a,
  input  wire logic [level_regfile_pkg::WORD_W-1:0] b,
  input  wire level_regfile_pkg::alu_op_e            op,
  output level_regfile_pkg::alu_out_s                out
);
  import level_regfile_pkg::*;

  logic [WORD_W-1:0] b_eff;
  logic [WORD_W:0]   sum;
  logic              is_sub;

  always_comb begin
    is_sub = (op == ALU_SUB);
    // Subtraction adds the inverted subtrahend plus one, so no sign mode is needed.
    b_eff  = is_sub ? (b ^ WORD_ONES) : b;
    sum    = {1'b0, a} + {1'b0, b_eff} + {{WORD_W{1'b0}}, is_sub};
    out.result   = sum[WORD_W-1:0];
    out.carry    = 1'b0;
    out.overflow = 1'b0;
    unique case (op)
      ALU_ADD, ALU_SUB: begin
        // Carry reports unsigned overflow, so for subtract it is the borrow.
        out.carry    = is_sub ? ~sum[WORD_W] : sum[WORD_W];
        // Result beyond 7FFF or below 8000 flips the sign against both operands.
        out.overflow = (a[SIGN_BIT] == b_eff[SIGN_BIT]) &&
                       (sum[SIGN_BIT] != a[SIGN_BIT]);
      end
      ALU_AND: out.result = a & b;
      ALU_OR:  out.result = a | b;
      ALU_XOR: out.result = a ^ b;
      default: out.result = sum[WORD_W-1:0];
    endcase
  end

endmodule : alu16

//--- rtl/level_register_file_alu.sv
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
module level_register_file_alu (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic [level_regfile_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                                   avs_read,
  input  wire logic                                   avs_write,
  input  wire logic [level_regfile_pkg::BUS_W-1:0]    avs_writedata,
  input  wire logic [level_regfile_pkg::BE_W-1:0]     avs_byteenable,
  output logic      [level_regfile_pkg::BUS_W-1:0]    avs_readdata,
  output logic                                        avs_waitrequest,
  output logic      [level_regfile_pkg::LEVELS-1:0]   level_irq_enable,
  output logic                                        class_irq,
  output logic                                        program_check
);
  import level_regfile_pkg::*;

  logic [WORD_W-1:0] gpr_reg   [LEVELS][GPRS];
  logic [WORD_W-1:0] gpr_next  [LEVELS][GPRS];
  logic [WORD_W-1:0] iar_reg   [LEVELS];
  logic [WORD_W-1:0] iar_next  [LEVELS];
  logic [WORD_W-1:0] lsr_reg   [LEVELS];
  logic [WORD_W-1:0] lsr_next  [LEVELS];

  logic [WORD_W-1:0] operand_reg, operand_next;
  logic [WORD_W-1:0] result_reg, result_next;
  logic [WORD_W-1:0] psw_reg, psw_next;
  logic [WORD_W-1:0] sar_reg, sar_next;
  logic [WORD_W-1:0] conbuf_reg, conbuf_next;
  logic [WORD_W-1:0] current_instr_addr_reg_reg, current_instr_addr_reg_next;
  logic [LEVELS-1:0] mask_reg, mask_next;
  lsb_sel_s          lsb_sel_reg, lsb_sel_next;
  logic              stopped_reg, stopped_next;
  logic [BUS_W-1:0]  readdata_reg, readdata_next;
  logic              waitrequest_reg, waitrequest_next;
  logic              class_irq_reg, class_irq_next;
  logic              prog_chk_reg, prog_chk_next;

  logic              accept;
  logic              do_cmd;
  logic              spec_check;
  cmd_s              cmd;
  logic [WORD_W-1:0] rd_val;
  logic [WORD_W-1:0] wr_val;
  logic [WORD_W-1:0] alu_a, alu_b;
  alu_op_e           alu_op;
  alu_out_s          alu_out;

  // Merges the two low byte lanes of a bus write into a 16-bit register.
  function automatic logic [WORD_W-1:0] be_merge(input logic [WORD_W-1:0] old_v,
                                                 input logic [BUS_W-1:0]  wd,
                                                 input logic [BE_W-1:0]   be);
    logic [WORD_W-1:0] v;
    v = old_v;
    if (be[0]) begin
      v[BYTE_W-1:0] = wd[BYTE_W-1:0];
    end
    if (be[1]) begin
      v[WORD_W-1:BYTE_W] = wd[WORD_W-1:BYTE_W];
    end
    return v;
  endfunction : be_merge

  // Loads the result indicators; the control bits are kept as they are.
  function automatic logic [WORD_W-1:0] set_flags(input logic [WORD_W-1:0] level_status_reg,
                                                  input logic [WORD_W-1:0] res,
                                                  input logic              c,
                                                  input logic              o);
    logic [WORD_W-1:0] v;
    v            = level_status_reg;
    v[LSR_EVEN]  = ~res[0];
    v[LSR_CARRY] = c;
    v[LSR_OVF]   = o;
    v[LSR_NEG]   = res[SIGN_BIT];
    v[LSR_ZERO]  = (res == WORD_ZERO);
    return v;
  endfunction : set_flags

  alu16 u_alu (
    .a   (alu_a),
    .b   (alu_b),
    .op  (alu_op),
    .out (alu_out)
  );

  // The slave takes a request while waitrequest is high and drops it for one cycle.
  assign accept = (avs_read | avs_write) & waitrequest_reg;
  assign do_cmd = accept & avs_write & ~avs_read & (avs_address == OFF_CMD);
  assign cmd    = cmd_s'(avs_writedata[WORD_W-1:0]);

  always_comb begin
    alu_a  = WORD_ZERO;
    alu_b  = WORD_ZERO;
    alu_op = ALU_ADD;
    unique case (cmd.op)
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
        alu_a = gpr_reg[cmd.level][cmd.r1];
        alu_b = gpr_reg[cmd.level][cmd.r2];
        unique case (cmd.op)
          OP_SUB:  alu_op = ALU_SUB;
          OP_AND:  alu_op = ALU_AND;
          OP_OR:   alu_op = ALU_OR;
          OP_XOR:  alu_op = ALU_XOR;
          default: alu_op = ALU_ADD;
        endcase
      end
      OP_NEG: begin
        alu_b  = gpr_reg[cmd.level][cmd.r2];
        alu_op = ALU_SUB;
      end
      OP_FETCH: begin
        alu_a = iar_reg[cmd.level];
        alu_b = INSTR_STEP;
      end
      OP_BRANCH: begin
        alu_a = gpr_reg[cmd.level][cmd.r2];
        alu_b = operand_reg;
      end
      OP_WORD_EA: begin
        alu_a = gpr_reg[cmd.level][cmd.r2];
        alu_b = {operand_reg[WORD_W-2:0], 1'b0};
      end
      default: begin
        alu_op = ALU_ADD;
      end
    endcase
  end

  always_comb begin
    gpr_next         = gpr_reg;
    iar_next         = iar_reg;
    lsr_next         = lsr_reg;
    operand_next     = operand_reg;
    result_next      = result_reg;
    psw_next         = psw_reg;
    sar_next         = sar_reg;
    conbuf_next      = conbuf_reg;
    current_instr_addr_reg_next        = current_instr_addr_reg_reg;
    mask_next        = mask_reg;
    lsb_sel_next     = lsb_sel_reg;
    stopped_next     = stopped_reg;
    readdata_next    = readdata_reg;
    waitrequest_next = 1'b1;
    prog_chk_next    = 1'b0;
    spec_check       = 1'b0;
    rd_val           = WORD_ZERO;
    wr_val           = be_merge(WORD_ZERO, avs_writedata, avs_byteenable);

    if (accept && avs_read) begin
      waitrequest_next = 1'b0;
      unique case (avs_address)
        OFF_OPERAND: rd_val = operand_reg;
        OFF_RESULT:  rd_val = result_reg;
        OFF_LSR:     rd_val = lsr_reg[lsb_sel_reg.level] & LSR_USED_MASK;
        OFF_MASK:    rd_val = {{(WORD_W-LEVELS){1'b0}}, mask_reg};
        OFF_PSW: begin
          // Copy-status-and-reset is the only path that shows the status word.
          rd_val   = psw_reg;
          psw_next = WORD_ZERO;
        end
        OFF_SAR:     rd_val = sar_reg;
        OFF_CONBUF:  rd_val = conbuf_reg;
        OFF_CURRENT_INSTR_ADDR_REG:    rd_val = current_instr_addr_reg_reg;
        OFF_IAR:     rd_val = iar_reg[lsb_sel_reg.level];
        OFF_STATUS: begin
          rd_val[ST_STOPPED] = stopped_reg;
          rd_val[ST_CLASS]   = class_irq_reg;
        end
        OFF_LSB_SEL: rd_val = WORD_W'(lsb_sel_reg);
        OFF_LSB_DAT: begin
          // Word index 10 is the tail of the 22-byte block and reads as zero.
          if (lsb_sel_reg.word == LSB_IDX_IAR) begin
            rd_val = iar_reg[lsb_sel_reg.level];
          end else if (lsb_sel_reg.word == LSB_IDX_LSR) begin
            rd_val = lsr_reg[lsb_sel_reg.level] & LSR_USED_MASK;
          end else if (lsb_sel_reg.word < LSB_IDX_GPR0 + 4'(GPRS)) begin
            rd_val = gpr_reg[lsb_sel_reg.level]
                            [GPR_W'(lsb_sel_reg.word - LSB_IDX_GPR0)];
          end
        end
        default:     rd_val = WORD_ZERO;
      endcase
      readdata_next = {{(BUS_W-WORD_W){1'b0}}, rd_val};
    end else if (accept && avs_write) begin
      waitrequest_next = 1'b0;
      unique case (avs_address)
        OFF_OPERAND: operand_next = be_merge(operand_reg, avs_writedata, avs_byteenable);
        OFF_LSR: begin
          lsr_next[lsb_sel_reg.level] = be_merge(lsr_reg[lsb_sel_reg.level], avs_writedata,
                                                 avs_byteenable) & LSR_USED_MASK;
        end
        OFF_MASK:    mask_next = LEVELS'(be_merge({{(WORD_W-LEVELS){1'b0}}, mask_reg},
                                                 avs_writedata, avs_byteenable));
        OFF_SAR:     sar_next = be_merge(sar_reg, avs_writedata, avs_byteenable);
        OFF_CONBUF:  conbuf_next = be_merge(conbuf_reg, avs_writedata, avs_byteenable);
        OFF_IAR: begin
          iar_next[lsb_sel_reg.level] = be_merge(iar_reg[lsb_sel_reg.level], avs_writedata,
                                                 avs_byteenable);
        end
        OFF_LSB_SEL: lsb_sel_next = lsb_sel_s'(wr_val);
        default: begin
          result_next = result_reg;
        end
      endcase
    end

    if (do_cmd) begin
      unique case (cmd.op)
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
          gpr_next[cmd.level][cmd.r1] = alu_out.result;
          result_next                 = alu_out.result;
          lsr_next[cmd.level] = set_flags(lsr_reg[cmd.level], alu_out.result,
                                          alu_out.carry, alu_out.overflow);
        end
        OP_NEG: begin
          gpr_next[cmd.level][cmd.r1] = alu_out.result;
          result_next                 = alu_out.result;
          lsr_next[cmd.level] = set_flags(lsr_reg[cmd.level], alu_out.result,
                                          alu_out.carry, alu_out.overflow);
        end
        OP_LOAD: begin
          gpr_next[cmd.level][cmd.r1] = operand_reg;
          result_next                 = operand_reg;
        end
        OP_LOAD_S8: begin
          gpr_next[cmd.level][cmd.r1] = {{(WORD_W-BYTE_W){operand_reg[BYTE_W-1]}},
                                         operand_reg[BYTE_W-1:0]};
          result_next = {{(WORD_W-BYTE_W){operand_reg[BYTE_W-1]}},
                         operand_reg[BYTE_W-1:0]};
        end
        OP_COPY_CON: begin
          gpr_next[cmd.level][cmd.r1] = conbuf_reg;
          result_next                 = conbuf_reg;
        end
        OP_FETCH: begin
          if (!stopped_reg) begin
            sar_next = iar_reg[cmd.level];
            if (iar_reg[cmd.level][0]) begin
              spec_check = 1'b1;
            end else begin
              current_instr_addr_reg_next           = iar_reg[cmd.level];
              iar_next[cmd.level] = alu_out.result;
            end
          end
        end
        OP_BRANCH: begin
          if (!stopped_reg) begin
            result_next = alu_out.result;
            if (alu_out.result[0]) begin
              spec_check = 1'b1;
            end else begin
              iar_next[cmd.level] = alu_out.result;
            end
          end
        end
        OP_WORD_EA: begin
          // An odd base makes the word address invalid, so no storage cycle starts.
          if (gpr_reg[cmd.level][cmd.r2][0]) begin
            spec_check = 1'b1;
          end else begin
            sar_next    = alu_out.result;
            result_next = alu_out.result;
          end
        end
        OP_RUN:      stopped_next = 1'b0;
        OP_STOP:     stopped_next = 1'b1;
        OP_READ_GPR: result_next = gpr_reg[cmd.level][cmd.r1];
        default: begin
          result_next = result_reg;
        end
      endcase
    end

    // A check raised during a status copy survives the clear.
    if (spec_check) begin
      psw_next[PSW_SPEC_BIT] = 1'b1;
      prog_chk_next          = 1'b1;
    end
    class_irq_next = |(psw_next & PSW_ERR_MASK);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int l = 0; l < LEVELS; l++) begin
        for (int g = 0; g < GPRS; g++) begin
          gpr_reg[l][g] <= WORD_ZERO;
        end
        iar_reg[l] <= WORD_ZERO;
        lsr_reg[l] <= WORD_ZERO;
      end
      operand_reg     <= WORD_ZERO;
      result_reg      <= WORD_ZERO;
      psw_reg         <= WORD_ZERO;
      sar_reg         <= WORD_ZERO;
      conbuf_reg      <= WORD_ZERO;
      current_instr_addr_reg_reg        <= WORD_ZERO;
      mask_reg        <= MASK_RESET;
      lsb_sel_reg     <= lsb_sel_s'(WORD_ZERO);
      stopped_reg     <= 1'b0;
      readdata_reg    <= '0;
      waitrequest_reg <= 1'b1;
      class_irq_reg   <= 1'b0;
      prog_chk_reg    <= 1'b0;
    end else begin
      gpr_reg         <= gpr_next;
      iar_reg         <= iar_next;
      lsr_reg         <= lsr_next;
      operand_reg     <= operand_next;
      result_reg      <= result_next;
      psw_reg         <= psw_next;
      sar_reg         <= sar_next;
      conbuf_reg      <= conbuf_next;
      current_instr_addr_reg_reg        <= current_instr_addr_reg_next;
      mask_reg        <= mask_next;
      lsb_sel_reg     <= lsb_sel_next;
      stopped_reg     <= stopped_next;
      readdata_reg    <= readdata_next;
      waitrequest_reg <= waitrequest_next;
      class_irq_reg   <= class_irq_next;
      prog_chk_reg    <= prog_chk_next;
    end
  end

  assign avs_readdata     = readdata_reg;
  assign avs_waitrequest  = waitrequest_reg;
  assign level_irq_enable = mask_reg;
  assign class_irq        = class_irq_reg;
  assign program_check    = prog_chk_reg;

endmodule : level_register_file_alu

//--- sim/level_regfile_checker.sv
`timescale 1ns/1ns
module level_regfile_checker (
  input wire logic                                  clk,
  input wire logic                                  rst_n,
  input wire logic [level_regfile_pkg::ADDR_W-1:0]  avs_address,
  input wire logic                                  avs_read,
  input wire logic                                  avs_write,
  input wire logic [level_regfile_pkg::BUS_W-1:0]   avs_writedata,
  input wire logic [level_regfile_pkg::BE_W-1:0]    avs_byteenable,
  input wire logic [level_regfile_pkg::BUS_W-1:0]   avs_readdata,
  input wire logic                                  avs_waitrequest,
  input wire logic [level_regfile_pkg::LEVELS-1:0]  level_irq_enable,
  input wire logic                                  class_irq,
  input wire logic                                  program_check
);
  import level_regfile_pkg::*;

  logic mask_acc;

  // A write with read also high counts as a read, so it must not move the mask.
  assign mask_acc = avs_write && !avs_read && avs_waitrequest && avs_address == OFF_MASK
                    && avs_byteenable[0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  rd_upper_a: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  pc_pulse_a: assert property (program_check |=> !program_check)
    else $error("program check longer than one cycle");
  pc_class_a: assert property (program_check |-> class_irq && !avs_waitrequest)
    else $error("program check without class interrupt or answer");
  class_cause_a: assert property ($rose(class_irq) |-> program_check)
    else $error("class interrupt rose without a program check");
  mask_write_a: assert property (mask_acc |=> level_irq_enable == $past(avs_writedata[3:0]))
    else $error("mask write not reflected on level enables");
  mask_hold_a: assert property (!$stable(level_irq_enable) |-> $past(mask_acc) || !$past(rst_n))
    else $error("level enables changed without a mask write");
endmodule : level_regfile_checker

bind level_register_file_alu level_regfile_checker chk (.clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .level_irq_enable, .class_irq, .program_check);

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import level_regfile_pkg::*;

  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [BUS_W-1:0]  avs_writedata;
  logic [BE_W-1:0]   avs_byteenable;
  logic [BUS_W-1:0]  avs_readdata;
  logic              avs_waitrequest;
  logic [LEVELS-1:0] level_irq_enable;
  logic              class_irq;
  logic              program_check;
  logic [BUS_W-1:0]  rd;
  int                num_errors;
  int                tests_run;
  int                cycles;
  int                pc_count;
  logic [15:0]       ta [9] = '{16'h7FFF, 16'hFFFF, 16'h0002, 16'h8000, 16'hF0F0, 16'hF0F0,
                                16'hF0F0, 16'h1234, 16'h1234};
  logic [15:0]       tb [9] = '{16'h0001, 16'h0001, 16'h0007, 16'h0001, 16'h3C3C, 16'h3C3C,
                                16'h3C3C, 16'h0001, 16'h8000};
  logic [15:0]       tr [9] = '{16'h8000, 16'h0000, 16'hFFFB, 16'h7FFF, 16'h3030, 16'hFCFC,
                                16'hCCCC, 16'hFFFF, 16'h8000};
  logic [1:0]        tf [9] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
  cmd_op_e           top [9] = '{OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_AND, OP_OR, OP_XOR,
                                 OP_NEG, OP_NEG};

  level_register_file_alu uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .level_irq_enable,
    .class_irq, .program_check);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The pulse stands for one cycle only, so it is counted at every edge rather than polled.
  always @(posedge clk) begin
    cycles++;
    if (program_check === 1'b1) pc_count++;
    if (cycles == 3000) begin
      num_errors++;
      $display("ERROR %0t run did not complete", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One edge passes after release so the next request never lands in the same time step.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    xfer(1'b0, a, 16'h0000);
    check(rd[15:0], exp);
  endtask : rd_chk

  task automatic cmd(input cmd_op_e op, input logic [1:0] lv, input logic [2:0] r1,
                     input logic [2:0] r2);
    cmd_s c;
    c = '{4'h0, r2, r1, lv, op};
    xfer(1'b1, OFF_CMD, c);
  endtask : cmd

  task automatic load(input logic [1:0] lv, input logic [2:0] r, input logic [15:0] v);
    xfer(1'b1, OFF_OPERAND, v);
    cmd(OP_LOAD, lv, r, 3'h0);
  endtask : load

  initial begin
    rst_n          = 1'b0;
    avs_address    = 6'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(OFF_MASK, 16'h0000);
    xfer(1'b1, OFF_MASK, 16'h000A);
    rd_chk(OFF_MASK, 16'h000A);
    check({12'h000, level_irq_enable}, 16'h000A);
    xfer(1'b1, OFF_LSR, 16'hFFFF);
    rd_chk(OFF_LSR, 16'hF8F0);
    rd_chk(6'h3C, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      load(2'h0, 3'h1, ta[i]);
      load(2'h0, 3'h2, tb[i]);
      cmd(top[i], 2'h0, 3'h1, 3'h2);
      rd_chk(OFF_RESULT, tr[i]);
      xfer(1'b0, OFF_LSR, 16'h0000);
      check({14'h0000, rd[14:13]}, {14'h0000, tf[i]});
    end
    xfer(1'b1, OFF_OPERAND, 16'h00FD);
    cmd(OP_LOAD_S8, 2'h0, 3'h3, 3'h0);
    rd_chk(OFF_RESULT, 16'hFFFD);
    xfer(1'b1, OFF_OPERAND, 16'h007F);
    cmd(OP_LOAD_S8, 2'h0, 3'h3, 3'h0);
    rd_chk(OFF_RESULT, 16'h007F);
    load(2'h1, 3'h1, 16'h2222);
    cmd(OP_READ_GPR, 2'h0, 3'h1, 3'h0);
    rd_chk(OFF_RESULT, 16'h8000);
    cmd(OP_READ_GPR, 2'h1, 3'h1, 3'h0);
    rd_chk(OFF_RESULT, 16'h2222);
    xfer(1'b1, OFF_LSB_SEL, 16'h0013);
    rd_chk(OFF_LSB_DAT, 16'h2222);
    xfer(1'b1, OFF_LSB_SEL, 16'h001A);
    rd_chk(OFF_LSB_DAT, 16'h0000);
    xfer(1'b1, OFF_CONBUF, 16'h5A5A);
    cmd(OP_COPY_CON, 2'h0, 3'h4, 3'h0);
    cmd(OP_READ_GPR, 2'h0, 3'h4, 3'h0);
    rd_chk(OFF_RESULT, 16'h5A5A);
    xfer(1'b1, OFF_LSB_SEL, 16'h0000);
    xfer(1'b1, OFF_IAR, 16'hFFFE);
    cmd(OP_FETCH, 2'h0, 3'h0, 3'h0);
    rd_chk(OFF_IAR, 16'h0000);
    rd_chk(OFF_CURRENT_INSTR_ADDR_REG, 16'hFFFE);
    rd_chk(OFF_SAR, 16'hFFFE);
    xfer(1'b1, OFF_IAR, 16'h0011);
    cmd(OP_FETCH, 2'h0, 3'h0, 3'h0);
    check(16'(pc_count), 16'h0001);
    rd_chk(OFF_IAR, 16'h0011);
    rd_chk(OFF_STATUS, 16'h0002);
    rd_chk(OFF_PSW, 16'h8000);
    rd_chk(OFF_PSW, 16'h0000);
    check({15'h0000, class_irq}, 16'h0000);
    load(2'h0, 3'h2, 16'h0100);
    xfer(1'b1, OFF_OPERAND, 16'h0003);
    cmd(OP_BRANCH, 2'h0, 3'h0, 3'h2);
    check(16'(pc_count), 16'h0002);
    xfer(1'b1, OFF_OPERAND, 16'h0004);
    cmd(OP_BRANCH, 2'h0, 3'h0, 3'h2);
    rd_chk(OFF_IAR, 16'h0104);
    load(2'h0, 3'h5, 16'hFFFE);
    xfer(1'b1, OFF_OPERAND, 16'h0002);
    cmd(OP_WORD_EA, 2'h0, 3'h0, 3'h5);
    rd_chk(OFF_SAR, 16'h0002);
    load(2'h0, 3'h5, 16'h0003);
    cmd(OP_WORD_EA, 2'h0, 3'h0, 3'h5);
    check(16'(pc_count), 16'h0003);
    rd_chk(OFF_SAR, 16'h0002);
    cmd(OP_STOP, 2'h0, 3'h0, 3'h0);
    cmd(OP_FETCH, 2'h0, 3'h0, 3'h0);
    rd_chk(OFF_STATUS, 16'h0003);
    rd_chk(OFF_IAR, 16'h0104);
    rd_chk(OFF_CURRENT_INSTR_ADDR_REG, 16'hFFFE);
    cmd(OP_RUN, 2'h0, 3'h0, 3'h0);
    rd_chk(OFF_STATUS, 16'h0002);
    avs_byteenable <= 4'h1;
    xfer(1'b1, OFF_SAR, 16'hABCD);
    avs_byteenable <= 4'hF;
    rd_chk(OFF_SAR, 16'h00CD);
    finish_test();
  end
endmodule : tb_top
